// ### cts_pkg.sv
// Purpose: shared constants and types of the cycle-timed sequencer
// Assumes: one system clock, opcode bytes prefetched by the fetch unit
// Notes:   opcodes follow the standard 8-bit accumulator instruction set
`default_nettype none

package cts_pkg;

  // ************************************************************
  // clock and addressing
  // ************************************************************
  localparam int unsigned CLK_HZ      = 100_000_000;
  localparam logic [15:0] PC_RESET    = 16'h0000;
  localparam int unsigned SPC_SEL_BIT = 7;
  localparam int unsigned PAGE_LSB    = 11;

  // ************************************************************
  // opcodes the sequencer treats specially
  // ************************************************************
  localparam logic [7:0] OP_NOP   = 8'h00;
  localparam logic [7:0] OP_SPARE = 8'hA5;
  localparam logic [7:0] OP_SJMP  = 8'h80;
  localparam logic [7:0] OP_MUL   = 8'hA4;
  localparam logic [7:0] OP_DIV   = 8'h84;

  // ************************************************************
  // lengths and cycle counts
  // ************************************************************
  localparam logic [1:0] LEN_ONE   = 2'h1;
  localparam logic [1:0] LEN_TWO   = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;
  localparam logic [3:0] CYC_ONE   = 4'h1;

  typedef enum logic [2:0] {
    BR_NONE = 3'h0,
    BR_COND = 3'h1,
    BR_REL  = 3'h3,
    BR_PAGE = 3'h2,
    BR_LONG = 3'h6,
    BR_AIND = 3'h7,
    BR_RET  = 3'h5
  } cts_br_e;

  typedef enum logic [2:0] {
    CN_C    = 3'h0,
    CN_NC   = 3'h1,
    CN_Z    = 3'h3,
    CN_NZ   = 3'h2,
    CN_BIT  = 3'h6,
    CN_NBIT = 3'h7,
    CN_NE   = 3'h5,
    CN_DNZ  = 3'h4
  } cts_cnd_e;

  typedef enum logic [0:0] {
    ST_ISSUE = 1'b0,
    ST_BUSY  = 1'b1
  } cts_st_e;

endpackage

`default_nettype wire

// ### cts_dec.sv
// Purpose: opcode to length, base cycles and branch kind
// Assumes: op is the first byte of an instruction
// Notes:   base cycles of a conditional jump are its untaken count
`timescale 1ns/10ps
`default_nettype none

module cts_dec
  import cts_pkg::*;
(
  input  wire logic [7:0] op,
  output logic      [1:0] len,
  output logic      [3:0] cyc,
  output cts_br_e         br,
  output cts_cnd_e        cnd,
  output logic            dir_op
);

  // ************************************************************
  // column classes of the opcode map
  // ************************************************************
  wire logic [3:0] hi;
  wire logic       col_ind;
  wire logic       col_dir;
  wire logic       col_imm;
  wire logic       col_page;

  assign hi       = op[7:4];
  assign col_ind  = op[3:1] == 3'h3;
  assign col_dir  = op[3:0] == 4'h5;
  assign col_imm  = op[3:0] == 4'h4 && hi >= 4'h2 && hi <= 4'h9
                    && hi != 4'h8;
  assign col_page = op[3:0] == 4'h1;

  // ************************************************************
  // table: column defaults, then per-opcode overrides
  // ************************************************************
  always_comb
  begin
    len    = LEN_ONE;
    cyc    = CYC_ONE;
    br     = BR_NONE;
    cnd    = CN_C;
    dir_op = 1'b0;
    // bytes equal cycles unless listed below
    if (col_ind)
      cyc = 4'h2;
    if (col_dir)
    begin
      len    = LEN_TWO;
      cyc    = 4'h2;
      dir_op = 1'b1;
    end
    if (col_imm)
    begin
      len = LEN_TWO;
      cyc = 4'h2;
    end
    if (col_page)
    begin
      len = LEN_TWO;
      cyc = 4'h3;
      br  = BR_PAGE;
    end
    case (op) inside
      8'h02, 8'h12:
      begin
        len = LEN_THREE;
        cyc = 4'h4;
        br  = BR_LONG;
      end
      8'h10, 8'h20, 8'h30:
      begin
        len = LEN_THREE;
        cyc = 4'h3;
        br  = BR_COND;
        cnd = (op == 8'h30) ? CN_NBIT : CN_BIT;
      end
      8'h22, 8'h32:
      begin
        cyc = 4'h5;
        br  = BR_RET;
      end
      8'h40, 8'h50, 8'h60, 8'h70:
      begin
        len = LEN_TWO;
        cyc = 4'h2;
        br  = BR_COND;
        cnd = cts_cnd_e'({1'b0, op[5], op[5] ^ op[4]});
      end
      8'h42, 8'h52, 8'h62, 8'hC0, 8'hD0, 8'h86, 8'h87, [8'h88:8'h8F],
      8'hA6, 8'hA7, [8'hA8:8'hAF]:
      begin
        len    = LEN_TWO;
        cyc    = 4'h2;
        dir_op = 1'b1;
      end
      8'h43, 8'h53, 8'h63, 8'h75, 8'h85:
      begin
        len    = LEN_THREE;
        cyc    = 4'h3;
        dir_op = 1'b1;
      end
      8'h72, 8'h82, 8'h92, 8'hA0, 8'hA2, 8'hB0, 8'hB2, 8'hC2, 8'hD2,
      8'h76, 8'h77, [8'h78:8'h7F]:
      begin
        len = LEN_TWO;
        cyc = 4'h2;
      end
      8'h73:
      begin
        cyc = 4'h3;
        br  = BR_AIND;
      end
      8'h80:
      begin
        len = LEN_TWO;
        cyc = 4'h3;
        br  = BR_REL;
      end
      8'h83, 8'h93, 8'hE0, 8'hE2, 8'hE3, 8'hF0, 8'hF2, 8'hF3:
        cyc = 4'h3;
      8'h84:
        cyc = 4'h8;
      8'hA4:
        cyc = 4'h4;
      8'h90:
      begin
        len = LEN_THREE;
        cyc = 4'h3;
      end
      // spare sits in the direct column: undo its defaults
      8'hA5:
      begin
        len    = LEN_ONE;
        cyc    = CYC_ONE;
        dir_op = 1'b0;
      end
      8'hB4, [8'hB8:8'hBF], 8'hB5, 8'hB6, 8'hB7:
      begin
        len    = LEN_THREE;
        cyc    = (op[3] || op == 8'hB4) ? 4'h3 : 4'h4;
        br     = BR_COND;
        cnd    = CN_NE;
        dir_op = op == 8'hB5;
      end
      8'hD5, [8'hD8:8'hDF]:
      begin
        len    = op[3] ? LEN_TWO : LEN_THREE;
        cyc    = op[3] ? 4'h2 : 4'h3;
        br     = BR_COND;
        cnd    = CN_DNZ;
        dir_op = !op[3];
      end
      default:
        ;
    endcase
  end

endmodule

`default_nettype wire

// ### cts_seq.sv
// Purpose: decode and cycle-timing sequencer of the 8-bit core
// Assumes: fetch unit shows the bytes at PC with CODE_VALID;
//          datapath flags are valid in the issue cycle
// Notes:   one instruction in flight; condition sampled at issue
//
// Contract
// - decode uses the standard instruction encodings
// - timing counted only in system clocks
// - most instructions: cycles equal byte count
// - untaken conditional branch one cycle shorter
// - add forms: register 1, direct/immediate 2
// - multiply four cycles, divide eight cycles
// - logic immediate into direct: three bytes, cycles
// - single-byte accumulator ops take one cycle
// - code memory reads: one byte, three cycles
// - external data moves: one byte, three cycles
// - pointer immediate load: three bytes, cycles
// - push and pop: two bytes, two cycles
// - carry, zero, register-decrement jumps: two/three
// - bit jumps and direct decrement: three/four
// - compare jumps: memory four/five, immediate three/four
// - calls three/four cycles, returns five
// - page, short, indexed jumps three; long four
// - offset is signed, from next instruction
// - page target stays in the 2 kB page of the next instruction
// - direct below 0x80 is RAM, else register
// - spare opcode behaves as no-operation
`timescale 1ns/10ps
`default_nettype none

module cts_seq
  import cts_pkg::*;
(
  input  wire logic        CLK_SYS,
  input  wire logic        RESET_N,
  input  wire logic        CODE_VALID,
  input  wire logic [7:0]  CODE_B0,
  input  wire logic [7:0]  CODE_B1,
  input  wire logic [7:0]  CODE_B2,
  input  wire logic        COND_CARRY,
  input  wire logic        COND_ACC_ZERO,
  input  wire logic        COND_BIT,
  input  wire logic        COND_CMP_NE,
  input  wire logic        COND_DEC_NZ,
  input  wire logic [7:0]  ACC_VALUE,
  input  wire logic [15:0] DATA_POINTER_16,
  input  wire logic [15:0] RET_ADDR,
  output logic      [15:0] PC,
  output logic             ISSUE,
  output logic             DONE,
  output logic             BUSY,
  output logic      [7:0]  OPCODE,
  output logic      [7:0]  OPERAND1,
  output logic      [7:0]  OPERAND2,
  output logic      [15:0] INSTR_ADDR,
  output logic      [1:0]  INSTR_LEN,
  output logic      [3:0]  INSTR_CYCLES,
  output logic             TAKEN,
  output logic             DIRECT_VALID,
  output logic             DIRECT_SPECIAL_FUNCTION_REGISTER
);

  // ************************************************************
  // decode
  // ************************************************************
  logic     [1:0] d_len;
  logic     [3:0] d_cyc;
  cts_br_e        d_br;
  cts_cnd_e       d_cnd;
  logic           d_dir;

  cts_dec cts_dec_inst (
    .op     (CODE_B0),
    .len    (d_len),
    .cyc    (d_cyc),
    .br     (d_br),
    .cnd    (d_cnd),
    .dir_op (d_dir)
  );

  // ************************************************************
  // state
  // ************************************************************
  cts_st_e     st_ff;
  cts_st_e     nxt_st;
  logic [3:0]  cnt_ff;
  logic [3:0]  nxt_cnt;
  logic [15:0] pc_ff;
  logic [15:0] nxt_pc;
  logic [15:0] tgt_ff;
  logic        issue_ff;
  logic        done_ff;
  logic        busy_ff;
  logic [7:0]  op_ff;
  logic [7:0]  op1_ff;
  logic [7:0]  op2_ff;
  logic [15:0] iaddr_ff;
  logic [1:0]  len_ff;
  logic [3:0]  cyc_ff;
  logic        taken_ff;
  logic        cond_ff;
  logic        dv_ff;
  logic        spec_ff;

  // ************************************************************
  // branch condition and targets
  // ************************************************************
  wire logic        cond_true;
  wire logic        is_cond;
  wire logic        jump;
  wire logic [15:0] seq_next;
  wire logic [7:0]  rel_byte;
  wire logic [15:0] rel_tgt;
  wire logic [15:0] page_tgt;
  wire logic [15:0] long_tgt;
  wire logic [15:0] aind_tgt;
  wire logic [15:0] jump_tgt;
  wire logic [15:0] nxt_tgt;
  wire logic [3:0]  total;
  wire logic        accept;
  wire logic        busy_last;
  wire logic        last;
  wire logic [7:0]  canon_op;

  assign cond_true = (d_cnd == CN_C)    ?  COND_CARRY    :
                     (d_cnd == CN_NC)   ? !COND_CARRY    :
                     (d_cnd == CN_Z)    ?  COND_ACC_ZERO :
                     (d_cnd == CN_NZ)   ? !COND_ACC_ZERO :
                     (d_cnd == CN_BIT)  ?  COND_BIT      :
                     (d_cnd == CN_NBIT) ? !COND_BIT      :
                     (d_cnd == CN_NE)   ?  COND_CMP_NE   :
                                           COND_DEC_NZ;

  assign is_cond  = d_br == BR_COND;
  assign jump     = is_cond ? cond_true : (d_br != BR_NONE);
  assign seq_next = pc_ff + {14'h0000, d_len};

  // offset sits in the last byte: byte 2 of 3-byte jumps
  assign rel_byte = (d_len == LEN_THREE) ? CODE_B2 : CODE_B1;
  assign rel_tgt  = seq_next + {{8{rel_byte[7]}}, rel_byte};

  // bits 10:8 come from the opcode's top three bits, bits 7:0 from the following byte
  assign page_tgt = {seq_next[15:PAGE_LSB], CODE_B0[7:5],
                     CODE_B1};
  assign long_tgt = {CODE_B1, CODE_B2};
  assign aind_tgt = DATA_POINTER_16 + {8'h00, ACC_VALUE};

  assign jump_tgt = (d_br == BR_PAGE) ? page_tgt :
                    (d_br == BR_LONG) ? long_tgt :
                    (d_br == BR_AIND) ? aind_tgt :
                    (d_br == BR_RET)  ? RET_ADDR :
                                        rel_tgt;
  assign nxt_tgt  = jump ? jump_tgt : seq_next;

  // untaken is the base; a taken condition adds one clock
  assign total     = d_cyc + {3'h0, is_cond & cond_true};
  assign accept    = st_ff == ST_ISSUE && CODE_VALID;
  assign busy_last = st_ff == ST_BUSY && cnt_ff == CYC_ONE;
  assign last      = accept ? (total == CYC_ONE) : busy_last;
  assign canon_op  = (CODE_B0 == OP_SPARE) ? OP_NOP : CODE_B0;

  // ************************************************************
  // sequencer: plain clock counting, no machine-cycle grouping
  // ************************************************************
  always_comb
  begin
    nxt_st = st_ff;
    unique case (st_ff)
      ST_ISSUE:
        if (accept && total != CYC_ONE)
          nxt_st = ST_BUSY;
      ST_BUSY:
        if (busy_last)
          nxt_st = ST_ISSUE;
    endcase
  end

  assign nxt_cnt = accept ? total - CYC_ONE :
                   (st_ff == ST_BUSY) ? cnt_ff - CYC_ONE : cnt_ff;
  assign nxt_pc  = !last ? pc_ff : (accept ? nxt_tgt : tgt_ff);

  always_ff @(posedge CLK_SYS)
  begin
    if (!RESET_N)
    begin
      st_ff    <= ST_ISSUE;
      cnt_ff   <= 4'h0;
      pc_ff    <= PC_RESET;
      tgt_ff   <= PC_RESET;
      issue_ff <= 1'b0;
      done_ff  <= 1'b0;
      busy_ff  <= 1'b0;
    end
    else
    begin
      st_ff    <= nxt_st;
      cnt_ff   <= nxt_cnt;
      pc_ff    <= nxt_pc;
      tgt_ff   <= accept ? nxt_tgt : tgt_ff;
      issue_ff <= accept;
      done_ff  <= last;
      busy_ff  <= nxt_st == ST_BUSY;
    end
  end

  // ************************************************************
  // issued instruction, held until the next issue
  // ************************************************************
  always_ff @(posedge CLK_SYS)
  begin
    if (!RESET_N)
    begin
      op_ff    <= OP_NOP;
      op1_ff   <= 8'h00;
      op2_ff   <= 8'h00;
      iaddr_ff <= PC_RESET;
      len_ff   <= LEN_ONE;
      cyc_ff   <= CYC_ONE;
      taken_ff <= 1'b0;
      cond_ff  <= 1'b0;
      dv_ff    <= 1'b0;
      spec_ff  <= 1'b0;
    end
    else if (accept)
    begin
      op_ff    <= canon_op;
      op1_ff   <= CODE_B1;
      op2_ff   <= CODE_B2;
      iaddr_ff <= pc_ff;
      len_ff   <= d_len;
      cyc_ff   <= total;
      taken_ff <= jump;
      cond_ff  <= is_cond;
      dv_ff    <= d_dir;
      spec_ff  <= CODE_B1[SPC_SEL_BIT];
    end
  end

  assign PC           = pc_ff;
  assign ISSUE        = issue_ff;
  assign DONE         = done_ff;
  assign BUSY         = busy_ff;
  assign OPCODE       = op_ff;
  assign OPERAND1     = op1_ff;
  assign OPERAND2     = op2_ff;
  assign INSTR_ADDR   = iaddr_ff;
  assign INSTR_LEN    = len_ff;
  assign INSTR_CYCLES = cyc_ff;
  assign TAKEN        = taken_ff;
  assign DIRECT_VALID = dv_ff;
  assign DIRECT_SPECIAL_FUNCTION_REGISTER = spec_ff;

  // ************************************************************
  // checks
  // ************************************************************
  logic [3:0]       run_ff;
  wire logic [3:0]  span;
  wire logic [15:0] nx_addr;
  wire logic        mem_cmp;

  assign span    = issue_ff ? 4'h1 : run_ff + 4'h1;
  assign nx_addr = iaddr_ff + {14'h0000, len_ff};
  assign mem_cmp = op_ff inside {8'hB5, 8'hB6, 8'hB7};

  always_ff @(posedge CLK_SYS)
  begin
    if (!RESET_N)
      run_ff <= 4'h0;
    else
      run_ff <= span;
  end

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RESET_N);

  a_cycle_span:
    assert property (done_ff |-> span == cyc_ff)
    else $error("instruction length in clocks wrong");

  a_len_cycles:
    assert property (issue_ff && op_ff inside {[8'hE8:8'hEF],
                     8'hE5, 8'h85} |-> cyc_ff == {2'h0, len_ff})
    else $error("cycles differ from byte count");

  a_cond_save:
    assert property (issue_ff && cond_ff |-> cyc_ff == {2'h0, len_ff}
                     + {3'h0, mem_cmp} + {3'h0, taken_ff})
    else $error("branch cycle saving wrong");

  a_arith_reg:
    assert property (issue_ff && op_ff inside {[8'h28:8'h2F],
                     [8'h38:8'h3F], [8'h98:8'h9F]}
                     |-> len_ff == LEN_ONE && done_ff)
    else $error("register add not one cycle");

  a_arith_ind:
    assert property (issue_ff && op_ff inside {8'h26, 8'h37, 8'h96}
                     |-> len_ff == LEN_ONE && !done_ff ##1 done_ff)
    else $error("indirect add not two cycles");

  a_mul_time:
    assert property (issue_ff && op_ff == OP_MUL
                     |-> !done_ff [*3] ##1 done_ff)
    else $error("multiply not four cycles");

  a_div_time:
    assert property (issue_ff && op_ff == OP_DIV |-> ##7 done_ff)
    else $error("divide not eight cycles");

  a_logic_imm:
    assert property (issue_ff && op_ff inside {8'h43, 8'h53, 8'h63}
                     |-> len_ff == LEN_THREE ##2 done_ff)
    else $error("logic immediate to direct wrong");

  a_acc_single:
    assert property (issue_ff && op_ff inside {8'hE4, 8'hF4, 8'h03,
                     8'h13, 8'h23, 8'h33, 8'hC4, 8'hD4, 8'h04, 8'h14,
                     8'hA3} |-> done_ff)
    else $error("accumulator op not one cycle");

  a_code_read:
    assert property (issue_ff && op_ff inside {8'h83, 8'h93}
                     |-> len_ff == LEN_ONE ##2 done_ff)
    else $error("code read not three cycles");

  a_ext_move:
    assert property (issue_ff && op_ff inside {8'hE0, 8'hE2, 8'hE3,
                     8'hF0, 8'hF2, 8'hF3} |-> ##2 done_ff)
    else $error("external move not three cycles");

  a_ptr_load:
    assert property (issue_ff && op_ff == 8'h90
                     |-> len_ff == LEN_THREE ##2 done_ff)
    else $error("pointer load wrong");

  a_stack_move:
    assert property (issue_ff && op_ff inside {8'hC0, 8'hD0}
                     |-> len_ff == LEN_TWO ##1 done_ff)
    else $error("push or pop wrong");

  a_short_cond:
    assert property (issue_ff && op_ff inside {8'h40, 8'h50, 8'h60,
                     8'h70, [8'hD8:8'hDF]}
                     |-> cyc_ff == (taken_ff ? 4'h3 : 4'h2))
    else $error("short conditional jump timing");

  a_bit_jump:
    assert property (issue_ff && op_ff inside {8'h10, 8'h20, 8'h30,
                     8'hD5} |-> len_ff == LEN_THREE
                     && cyc_ff == (taken_ff ? 4'h4 : 4'h3))
    else $error("bit jump timing");

  a_cmp_jump:
    assert property (issue_ff && op_ff[7:4] == 4'hB && op_ff[3:2] != 2'h0
                     |-> cyc_ff == (mem_cmp ? 4'h4 : 4'h3)
                     + {3'h0, taken_ff})
    else $error("compare jump timing");

  a_return:
    assert property (issue_ff && op_ff inside {8'h22, 8'h32}
                     |-> ##4 done_ff && pc_ff == $past(RET_ADDR, 5))
    else $error("return not five cycles");

  a_jump_time:
    assert property (issue_ff && op_ff inside {8'h02, 8'h12}
                     |-> ##3 done_ff)
    else $error("long jump or call not four cycles");

  a_rel_target:
    assert property (done_ff && op_ff == OP_SJMP |-> pc_ff == nx_addr
                     + {{8{op1_ff[7]}}, op1_ff})
    else $error("relative target wrong");

  a_page_keep:
    assert property (done_ff && op_ff[4:0] == 5'h01
                     |-> pc_ff[15:11] == nx_addr[15:11]
                     && pc_ff[10:0] == {op_ff[7:5], op1_ff})
    else $error("page target left its page");

  a_dir_space:
    assert property (issue_ff && dv_ff
                     |-> spec_ff == (op1_ff >= 8'h80))
    else $error("direct space select wrong");

  a_spare_nop:
    assert property ($past(RESET_N) && $past(accept)
                     && $past(CODE_B0) == OP_SPARE
                     |-> op_ff == OP_NOP && done_ff && !taken_ff)
    else $error("spare opcode not a no-operation");

  c_taken: cover property (issue_ff && cond_ff && taken_ff);
  c_untaken: cover property (issue_ff && cond_ff && !taken_ff);
  c_divide: cover property (issue_ff && op_ff == OP_DIV ##7 done_ff);
  c_streak: cover property (issue_ff && done_ff [*3]);

endmodule

`default_nettype wire

// ### cts_pmem_model.sv
// Purpose: program memory model feeding the sequencer's fetch inputs
// Assumes: bench loads three bytes per write, then raises en
// Notes:   released bytes show the inverse of the last shown bytes
`timescale 1ns/10ps
`default_nettype none

module cts_pmem_model
  import cts_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic [15:0] pc,
  input  wire logic        en,
  input  wire logic        wr,
  input  wire logic [15:0] wa,
  input  wire logic [23:0] wd,
  output logic             code_valid,
  output logic      [7:0]  code_b0,
  output logic      [7:0]  code_b1,
  output logic      [7:0]  code_b2
);
  logic [7:0]  mem [0:65535];
  logic [23:0] held_ff = 24'h5AA55A;
  wire  [23:0] cur     = {mem[pc], mem[pc + 16'h0001], mem[pc + 16'h0002]};

  always_ff @(posedge clk_sys)
  begin
    if (wr)
    begin
      mem[wa]           <= wd[23:16];
      mem[wa + 16'h0001] <= wd[15:8];
      mem[wa + 16'h0002] <= wd[7:0];
    end
    if (en)
      held_ff <= cur;
  end

  // no stale bytes once released: the sequencer must not rely on them
  assign code_valid = en;
  assign {code_b0, code_b1, code_b2} = en ? cur : ~held_ff;
endmodule

`default_nettype wire

// ### cts_seq_bench.sv
// Purpose: self-checking bench of the cycle-timed sequencer
// Assumes: one instruction fetched at a time through the memory model
// Notes:   cycle counts measured from ISSUE to DONE at falling edges
`timescale 1ns/10ps
`default_nettype none

module cts_seq_bench
  import cts_pkg::*;
;
  // ************************************************************
  // stimulus and wiring
  // ************************************************************
  logic        clk_sys  = 1'b0;
  logic        reset_n  = 1'b0;
  logic        mem_en   = 1'b0;
  logic        mem_wr   = 1'b0;
  logic [15:0] mem_wa   = 16'h0000;
  logic [23:0] mem_wd   = 24'h000000;
  logic [4:0]  cond     = 5'h00;
  logic [7:0]  acc      = 8'h00;
  logic [15:0] dp16     = 16'h0000;
  logic [15:0] ret_addr = 16'h0000;
  logic [15:0] cur_pc   = 16'h0000;
  int          errors      = 0;
  int          check_count = 0;
  wire logic [15:0] pc, instr_addr;
  wire logic [7:0]  opcode, operand1, operand2, b0, b1, b2;
  wire logic [3:0]  instr_cycles;
  wire logic [1:0]  instr_len;
  wire logic        issue, done, busy, taken, dvalid, dspec, cvalid;

  // op, len, cycles
  localparam logic [40:0][15:0] PT = {16'h2811, 16'h2522, 16'h2612,
    16'h2422, 16'h3811, 16'h3522, 16'h3612, 16'h3422, 16'h9811, 16'h9522,
    16'h9612, 16'h9422, 16'hA414, 16'h8418, 16'h5333, 16'h4333, 16'h6333,
    16'hE411, 16'hF411, 16'h2311, 16'h3311, 16'h0311, 16'h1311, 16'hC411,
    16'hD411, 16'h0411, 16'h1411, 16'hA311, 16'h9313, 16'h8313, 16'hE213,
    16'hF213, 16'hE013, 16'hF013, 16'h9033, 16'hC022, 16'hD022, 16'hA511,
    16'h0011, 16'h8533, 16'hE811};
  // op, len, untaken cycles, condition bit, polarity
  localparam logic [12:0][23:0] CT = {24'h402241, 24'h502240, 24'h602231,
    24'h702230, 24'hD82201, 24'h203321, 24'h303320, 24'h103321, 24'hD53301,
    24'hB53411, 24'hB43311, 24'hB83311, 24'hB63411};

  cts_pmem_model cts_pmem_model_inst (.clk_sys(clk_sys), .pc(pc),
    .en(mem_en), .wr(mem_wr), .wa(mem_wa), .wd(mem_wd),
    .code_valid(cvalid), .code_b0(b0), .code_b1(b1), .code_b2(b2));

  cts_seq cts_seq_inst (.CLK_SYS(clk_sys), .RESET_N(reset_n),
    .CODE_VALID(cvalid), .CODE_B0(b0), .CODE_B1(b1), .CODE_B2(b2),
    .COND_CARRY(cond[4]), .COND_ACC_ZERO(cond[3]), .COND_BIT(cond[2]),
    .COND_CMP_NE(cond[1]), .COND_DEC_NZ(cond[0]), .ACC_VALUE(acc),
    .DATA_POINTER_16(dp16), .RET_ADDR(ret_addr), .PC(pc), .ISSUE(issue),
    .DONE(done), .BUSY(busy), .OPCODE(opcode), .OPERAND1(operand1),
    .OPERAND2(operand2), .INSTR_ADDR(instr_addr), .INSTR_LEN(instr_len),
    .INSTR_CYCLES(instr_cycles), .TAKEN(taken), .DIRECT_VALID(dvalid),
    .DIRECT_SPECIAL_FUNCTION_REGISTER(dspec));

  always #5 clk_sys = ~clk_sys;

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic chk(input string nm, input logic [15:0] seen,
                     input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_sim;
    if (errors == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // one instruction: load bytes at cur_pc, let it issue, time it
  task automatic run(input logic [23:0] bytes, input logic [1:0] len,
                     input logic [3:0] cyc, input logic [15:0] npc,
                     input logic tk);
    int n;
    @(negedge clk_sys);
    mem_wa = cur_pc;
    mem_wd = bytes;
    mem_wr = 1'b1;
    @(negedge clk_sys);
    mem_wr = 1'b0;
    mem_en = 1'b1;
    n = 0;
    while (issue !== 1'b1 && n < 20)
    begin
      @(negedge clk_sys);
      n++;
    end
    // drop valid now so a one-cycle op is not followed by a second take
    mem_en = 1'b0;
    chk("issue", {15'h0000, issue}, 16'h0001);
    n = 1;
    while (done !== 1'b1 && n < 20)
    begin
      chk("busy", {15'h0000, busy}, 16'h0001);
      @(negedge clk_sys);
      n++;
    end
    chk("busy_done", {15'h0000, busy}, 16'h0000);
    chk("cycles", 16'(n), {12'h000, cyc});
    chk("cyc_out", {12'h000, instr_cycles}, {12'h000, cyc});
    chk("len", {14'h0000, instr_len}, {14'h0000, len});
    chk("opcode", {8'h00, opcode}, {8'h00, (bytes[23:16] == OP_SPARE) ?
        OP_NOP : bytes[23:16]});
    chk("taken", {15'h0000, taken}, {15'h0000, tk});
    chk("pc", pc, npc);
    chk("instr_addr", instr_addr, cur_pc);
    cur_pc = npc;
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_timing;
    logic [15:0] e;
    for (int i = 0; i < 41; i++)
    begin
      e = PT[i];
      run({e[15:8], 16'h5A3C},
          e[5:4], e[3:0],
          cur_pc + 16'(e[5:4]), 1'b0);
    end
  endtask

  task automatic t_direct;
    run(24'h257F00, 2'h2, 4'h2, cur_pc + 16'h0002, 1'b0);
    chk("dir_valid", {15'h0000, dvalid}, 16'h0001);
    chk("dir_special", {15'h0000, dspec}, 16'h0000);
    chk("operand1", {8'h00, operand1}, 16'h007F);
    run(24'hF58000, 2'h2, 4'h2, cur_pc + 16'h0002, 1'b0);
    chk("dir_special", {15'h0000, dspec}, 16'h0001);
    run(24'h280000, 2'h1, 4'h1, cur_pc + 16'h0001, 1'b0);
    chk("dir_valid", {15'h0000, dvalid}, 16'h0000);
  endtask

  // thirteen conditional jumps taken backwards, then not taken
  task automatic t_cond;
    logic [23:0] e;
    logic [4:0]  m;
    for (int i = 0; i < 13; i++)
    begin
      e = CT[i];
      m = 5'h01 << e[6:4];
      cond = e[0] ? m : ~m;
      run({e[23:16], 16'hF0F0}, e[13:12],
          e[11:8] + 4'h1,
          cur_pc + 16'(e[13:12]) + 16'hFFF0, 1'b1);
      cond = ~cond;
      run({e[23:16], 16'hF0F0}, e[13:12], e[11:8],
          cur_pc + 16'(e[13:12]), 1'b0);
    end
  endtask

  task automatic t_jumps;
    run(24'h0207FE, 2'h3, 4'h4, 16'h07FE, 1'b1);
    run(24'hE13400, 2'h2, 4'h3, 16'h0F34, 1'b1);
    run(24'h112000, 2'h2, 4'h3, 16'h0820, 1'b1);
    run(24'h80FE00, 2'h2, 4'h3, 16'h0820, 1'b1);
    run(24'h121234, 2'h3, 4'h4, 16'h1234, 1'b1);
    chk("operand2", {8'h00, operand2}, 16'h0034);
    acc  = 8'h10;
    dp16 = 16'h2000;
    run(24'h730000, 2'h1, 4'h3, 16'h2010, 1'b1);
    ret_addr = 16'h0100;
    run(24'h220000, 2'h1, 4'h5, 16'h0100, 1'b1);
    ret_addr = 16'h0200;
    run(24'h320000, 2'h1, 4'h5, 16'h0200, 1'b1);
  endtask

  // ************************************************************
  // main sequence and watchdog
  // ************************************************************
  initial
  begin
    repeat (16) @(negedge clk_sys);
    chk("rst_pc", pc, PC_RESET);
    chk("rst_busy", {15'h0000, busy}, 16'h0000);
    chk("rst_len", {14'h0000, instr_len}, 16'h0001);
    reset_n = 1'b1;
    t_timing;
    t_direct;
    t_cond;
    t_jumps;
    end_sim;
  end

  initial
  begin
    #100000;
    errors++;
    end_sim;
  end
endmodule

`default_nettype wire
